/* pic_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// --
// Core: acks requests, ends each service later
// --
module pic_core_model (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic en,
  input  wire logic irq_req,
  output var logic  core_ack,
  output var logic  core_eoi
);
  logic [3:0] depth;
  logic [3:0] gap;
  // Gaps between steps leave room for a higher request to preempt
  always @(posedge clk) begin
    core_ack <= 1'b0;
    core_eoi <= 1'b0;
    gap <= gap + 4'h1;
    if (sys_rst || !en) begin
      depth <= 4'h0;
      gap <= 4'h0;
    end else if (core_ack && irq_req) begin
      depth <= depth + 4'h1;
    end else if (!core_ack && !core_eoi && irq_req && gap > 4'h2) begin
      core_ack <= 1'b1;
      gap <= 4'h0;
    end else if (!core_ack && !core_eoi && depth != 4'h0 && gap > 4'h6) begin
      core_eoi <= 1'b1;
      depth <= depth - 4'h1;
      gap <= 4'h0;
    end
  end
endmodule : pic_core_model
`default_nettype wire

/* pic_defines.svh */
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// Source count, vector and priority widths
`define PIC_NUM_SRC      128
`define PIC_VEC_W        9
`define PIC_PRIO_W       4
`define PIC_NUM_LEVELS   16
`define PIC_NUM_SW       8
`define PIC_SW_IDX_W     3
`define PIC_SRC_IDX_W    7
`define PIC_SP_W         5

// Reset values
`define PIC_PRIO_RST     4'h0
`define PIC_MASK_RST     4'h0

`endif

/* pic_pkg.sv */
`default_nettype none
`include "pic_defines.svh"

package pic_pkg;
  typedef logic [`PIC_PRIO_W-1:0]    pic_prio_type;
  typedef logic [`PIC_VEC_W-1:0]     pic_vec_type;
  typedef logic [`PIC_SRC_IDX_W-1:0] pic_idx_type;
endpackage : pic_pkg

`default_nettype wire

/* pic_priority_interrupt_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pic_defines.svh"

module pic_priority_interrupt_unit #(
  parameter int NUM_SRC = `PIC_NUM_SRC,
  parameter int NUM_SW  = `PIC_NUM_SW
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic [NUM_SRC-1:0]         irq_src,
  input  wire logic                       prio_wr_en,
  input  wire pic_pkg::pic_idx_type       prio_wr_index,
  input  wire pic_pkg::pic_prio_type      prio_wr_data,
  input  wire logic                       mask_wr_en,
  input  wire pic_pkg::pic_prio_type      mask_wr_data,
  input  wire logic                       sw_set_en,
  input  wire logic                       sw_clr_en,
  input  wire logic [`PIC_SW_IDX_W-1:0]   sw_index,
  input  wire logic                       core_ack,
  input  wire logic                       core_eoi,
  input  wire logic                       nmi_in,
  output logic                            irq_req,
  output pic_pkg::pic_vec_type            irq_vector,
  output pic_pkg::pic_prio_type           irq_prio,
  output pic_pkg::pic_prio_type           cur_mask,
  output pic_pkg::pic_prio_type           svc_prio,
  output logic [NUM_SW-1:0]               sw_flags,
  output logic                            critical_irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic pic_pkg::pic_prio_type pic_max(input pic_pkg::pic_prio_type a,
                                                    input pic_pkg::pic_prio_type b);
    pic_max = (a > b) ? a : b;
  endfunction : pic_max

  // One-hot select of a software flag; shared by set, clear and the ack clear
  function automatic logic [NUM_SW-1:0] pic_sw_sel(input logic [`PIC_SW_IDX_W-1:0] idx);
    pic_sw_sel      = '0;
    pic_sw_sel[idx] = 1'b1;
  endfunction : pic_sw_sel

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pic_pkg::pic_prio_type prio_tab [NUM_SRC];
  pic_pkg::pic_prio_type next_prio_tab [NUM_SRC];
  pic_pkg::pic_prio_type prio_stack [`PIC_NUM_LEVELS];
  pic_pkg::pic_prio_type next_prio_stack [`PIC_NUM_LEVELS];
  logic [`PIC_SP_W-1:0]  sp;
  logic [`PIC_SP_W-1:0]  next_sp;
  pic_pkg::pic_prio_type next_cur_mask;
  pic_pkg::pic_prio_type next_svc_prio;
  logic [NUM_SW-1:0]     next_sw_flags;
  logic                  next_irq_req;
  pic_pkg::pic_vec_type  next_irq_vector;
  pic_pkg::pic_prio_type next_irq_prio;
  logic [NUM_SRC-1:0]    pending;
  pic_pkg::pic_prio_type win_prio;
  pic_pkg::pic_idx_type  win_idx;
  logic                  win_valid;
  pic_pkg::pic_prio_type threshold;
  logic                  ack_taken;
  logic                  ack_is_sw;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Software flags are ORed onto the low sources so they arbitrate like peripherals
  always_comb begin
    pending = irq_src;
    pending[NUM_SW-1:0] = irq_src[NUM_SW-1:0] | sw_flags;
  end

  // Scan from the top index down so the lowest index wins a tie
  always_comb begin
    win_prio  = `PIC_PRIO_RST;
    win_idx   = '0;
    win_valid = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i] && (!win_valid || prio_tab[i] >= win_prio)) begin
        win_prio  = prio_tab[i];
        win_idx   = pic_pkg::pic_idx_type'(i);
        win_valid = 1'b1;
      end
    end
  end

  // Running service level keeps equal and lower levels out, higher ones preempt
  assign threshold = pic_max(cur_mask, svc_prio);

  // A request is taken only while the line is up; an ack on an idle line is ignored
  assign ack_taken = core_ack && irq_req;
  assign ack_is_sw = irq_vector < pic_pkg::pic_vec_type'(NUM_SW);

  // ----------------------------------------------------------------
  // Next values and registers, one pair per group of state except the non-maskable path, a single flop
  // ----------------------------------------------------------------
  // Priority table: one entry rewritten per write pulse
  always_comb begin
    next_prio_tab = prio_tab;
    if (prio_wr_en) begin
      next_prio_tab[prio_wr_index] = prio_wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        prio_tab[i] <= `PIC_PRIO_RST;
      end
    end else begin
      prio_tab <= next_prio_tab;
    end
  end

  // Mask: the ceiling level that software raises around shared resources
  always_comb begin
    next_cur_mask = cur_mask;
    if (mask_wr_en) begin
      next_cur_mask = mask_wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_mask <= `PIC_MASK_RST;
    end else begin
      cur_mask <= next_cur_mask;
    end
  end

  // Software flags: clear, then the ack clear, then set, so a same-cycle set wins
  always_comb begin
    next_sw_flags = sw_flags;
    if (sw_clr_en) begin
      next_sw_flags = next_sw_flags & ~pic_sw_sel(sw_index);
    end
    if (ack_taken && ack_is_sw) begin
      next_sw_flags = next_sw_flags & ~pic_sw_sel(irq_vector[`PIC_SW_IDX_W-1:0]);  // Taken by core
    end
    if (sw_set_en) begin
      next_sw_flags = next_sw_flags | pic_sw_sel(sw_index);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_flags <= '0;
    end else begin
      sw_flags <= next_sw_flags;
    end
  end

  // Service stack: an ack pushes the running level, an end of interrupt pops it.
  // Each push needs a strictly higher level, so fifteen nested services at most;
  // the depth guard only protects against a core that acks outside the protocol.
  always_comb begin
    next_prio_stack = prio_stack;
    next_sp         = sp;
    next_svc_prio   = svc_prio;
    // Acknowledge takes priority over end of interrupt in the same cycle
    if (ack_taken) begin
      if (sp < `PIC_SP_W'(`PIC_NUM_LEVELS)) begin
        next_prio_stack[sp[`PIC_SP_W-2:0]] = svc_prio;
        next_sp = sp + `PIC_SP_W'(1);
      end
      next_svc_prio = irq_prio;
    end else if (core_eoi && sp != '0) begin
      next_svc_prio = prio_stack[sp[`PIC_SP_W-2:0] - 4'h1];
      next_sp = sp - `PIC_SP_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int j = 0; j < `PIC_NUM_LEVELS; j++) begin
        prio_stack[j] <= `PIC_PRIO_RST;
      end
      sp       <= '0;
      svc_prio <= `PIC_PRIO_RST;
    end else begin
      prio_stack <= next_prio_stack;
      sp         <= next_sp;
      svc_prio   <= next_svc_prio;
    end
  end

  // Request line and vector; the vector is the source index, unique per source
  always_comb begin
    next_irq_req    = win_valid && (win_prio > threshold);
    next_irq_vector = pic_pkg::pic_vec_type'(win_idx);
    next_irq_prio   = win_prio;
    // Drop the line for one cycle so the core never takes the same request twice
    if (ack_taken) begin
      next_irq_req = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_req    <= 1'b0;
      irq_vector <= '0;
      irq_prio   <= `PIC_PRIO_RST;
    end else begin
      irq_req    <= next_irq_req;
      irq_vector <= next_irq_vector;
      irq_prio   <= next_irq_prio;
    end
  end

  // Non-maskable path: a single flop, no arbitration or mask in the way
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      critical_irq <= 1'b0;
    end else begin
      critical_irq <= nmi_in;  // Bypasses arbitration and mask
    end
  end

endmodule : pic_priority_interrupt_unit

`default_nettype wire

/* pic_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// --
// Checker on the controller ports
// --
module pic_sva #(parameter int NUM_SW = 8) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic nmi_in,
  input wire logic critical_irq,
  input wire logic mask_wr_en,
  input wire pic_pkg::pic_prio_type mask_wr_data,
  input wire pic_pkg::pic_prio_type cur_mask,
  input wire logic irq_req,
  input wire pic_pkg::pic_prio_type irq_prio,
  input wire pic_pkg::pic_vec_type irq_vector,
  input wire pic_pkg::pic_prio_type svc_prio,
  input wire logic core_ack,
  input wire logic core_eoi,
  input wire logic sw_set_en,
  input wire logic [2:0] sw_index,
  input wire logic [NUM_SW-1:0] sw_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A taken ack starts one nested service
  sequence s_ack; core_ack && irq_req; endsequence
  property p_vec; irq_req |-> irq_vector[8:7] == 2'h0; endproperty
  property p_thr; irq_req |-> irq_prio > $past(cur_mask) && irq_prio > $past(svc_prio); endproperty
  property p_clr; s_ack |=> !irq_req; endproperty
  property p_svc; s_ack |=> svc_prio == $past(irq_prio); endproperty
  property p_eoi; core_eoi && !core_ack && svc_prio != 4'h0 |=> svc_prio < $past(svc_prio); endproperty
  property p_mask; mask_wr_en |=> cur_mask == $past(mask_wr_data); endproperty
  property p_set; sw_set_en |=> sw_flags[$past(sw_index)]; endproperty
  // The first edge after reset still sees a cleared copy
  property p_nmi; !$past(sys_rst) |-> critical_irq == $past(nmi_in); endproperty
  a_vec: assert property (p_vec) else $error("vector");
  a_thr: assert property (p_thr) else $error("threshold");
  a_clr: assert property (p_clr) else $error("ack clear");
  a_svc: assert property (p_svc) else $error("ack level");
  a_eoi: assert property (p_eoi) else $error("eoi");
  a_mask: assert property (p_mask) else $error("mask");
  a_set: assert property (p_set) else $error("sw set");
  a_nmi: assert property (p_nmi) else $error("nmi");
endmodule : pic_sva
bind pic_priority_interrupt_unit pic_sva #(.NUM_SW(NUM_SW)) u_pic_sva (.clk, .sys_rst, .nmi_in, .critical_irq,
  .mask_wr_en, .mask_wr_data, .cur_mask, .irq_req, .irq_prio, .irq_vector, .svc_prio, .core_ack, .core_eoi,
  .sw_set_en, .sw_index, .sw_flags);
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// --
// Bench
// --
module testbench;
  logic clk = 1'b0, sys_rst = 1'b1, en = 1'b0, nmi_in = 1'b0;
  logic prio_wr_en = 1'b0, mask_wr_en = 1'b0, sw_set_en = 1'b0, sw_clr_en = 1'b0;
  logic [127:0] irq_src = '0;
  logic [2:0] sw_index = '0;
  pic_pkg::pic_idx_type prio_wr_index = '0;
  pic_pkg::pic_prio_type prio_wr_data = '0, mask_wr_data = '0, irq_prio, cur_mask, svc_prio;
  pic_pkg::pic_vec_type irq_vector;
  logic irq_req, critical_irq, core_ack, core_eoi;
  logic [7:0] sw_flags;
  int err_total = 0, check_count = 0;
  // Row: source[15:9], priority[8:5], mask[4:1], request expected[0]
  logic [15:0] rows [4] = '{16'h2861, 16'hfffd, 16'h64aa, 16'h1200};
  always #2 clk = ~clk;
  pic_priority_interrupt_unit u_pic_priority_interrupt_unit (.clk, .sys_rst, .irq_src, .prio_wr_en, .prio_wr_index,
    .prio_wr_data, .mask_wr_en, .mask_wr_data, .sw_set_en, .sw_clr_en, .sw_index, .core_ack, .core_eoi, .nmi_in,
    .irq_req, .irq_vector, .irq_prio, .cur_mask, .svc_prio, .sw_flags, .critical_irq);
  pic_core_model u_pic_core_model (.clk, .sys_rst, .en, .irq_req, .core_ack, .core_eoi);
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // Priority and mask written together, one cycle pulse
  task automatic wr(input logic [6:0] i, input logic [3:0] p, input logic [3:0] m);
    @(negedge clk);
    {prio_wr_en, prio_wr_index, prio_wr_data, mask_wr_en, mask_wr_data} = {1'b1, i, p, 1'b1, m};
    @(negedge clk);
    {prio_wr_en, mask_wr_en} = 2'h0;
  endtask : wr
  task automatic setsw(input logic [2:0] i);
    sw_index = i;
    sw_set_en = 1'b1;
    @(negedge clk);
    sw_set_en = 1'b0;
  endtask : setsw
  // Bounded wait on the service level; a miss ends the run
  task automatic waitp(input logic [3:0] p);
    for (int i = 0; i < 80 && svc_prio !== p; i++) @(negedge clk);
    chk(svc_prio, p);
    if (svc_prio !== p) report_and_stop();
  endtask : waitp
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk({irq_req, critical_irq, cur_mask, svc_prio, sw_flags}, 24'h0);
    $display("reset test done");
    foreach (rows[k]) begin
      wr(rows[k][15:9], rows[k][8:5], rows[k][4:1]);
      irq_src[rows[k][15:9]] = 1'b1;
      repeat (3) @(negedge clk);
      chk({irq_req, irq_req ? irq_vector : 9'h0}, {rows[k][0], rows[k][0] ? {2'h0, rows[k][15:9]} : 9'h0});
      irq_src = '0;
      $display("row %0d done", k);
    end
    wr(7'h28, 4'h7, 4'h0);
    wr(7'h1e, 4'h7, 4'h0);
    wr(7'h02, 4'h9, 4'h0);
    irq_src[40] = 1'b1;
    irq_src[30] = 1'b1;
    repeat (3) @(negedge clk);
    chk(irq_vector, 24'h1e);
    $display("tie test done");
    setsw(3'h2);
    repeat (2) @(negedge clk);
    chk({sw_flags, irq_prio, 3'h0, irq_vector}, 24'h049002);
    en = 1'b1;
    waitp(4'h9);
    chk(sw_flags, 24'h0);
    waitp(4'h7);
    setsw(3'h2);
    waitp(4'h9);
    $display("preemption test done");
    wr(7'h00, 4'h0, 4'hf);
    nmi_in = 1'b1;
    repeat (3) @(negedge clk);
    chk({critical_irq, irq_req}, 24'h2);
    $display("nmi test done");
    // Mid-run reset with sources still high: priorities and mask must come back cleared
    nmi_in = 1'b0;
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk({irq_req, critical_irq, cur_mask, svc_prio, sw_flags, irq_prio}, 24'h0);
    $display("mid-run reset test done");
    // Set and clear of one flag in the same cycle: the set wins; a lone clear then drops it
    {sw_index, sw_set_en, sw_clr_en} = {3'h5, 2'h3};
    @(negedge clk);
    {sw_set_en, sw_clr_en} = 2'h1;
    chk(sw_flags, 24'h20);
    @(negedge clk);
    sw_clr_en = 1'b0;
    chk(sw_flags, 24'h0);
    $display("software flag test done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
